//--- verilog/cgl_pkg.sv
package cgl_pkg;

    // bus geometry and answers
    localparam int          ADDR_W       = 8;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;

    // register byte offsets
    localparam logic [7:0]  OFF_CTRL     = 8'h00;
    localparam logic [7:0]  OFF_STAT     = 8'h04;
    localparam logic [7:0]  OFF_EVT      = 8'h08;
    localparam logic [7:0]  OFF_MASK     = 8'h0c;
    localparam logic [7:0]  OFF_MODE     = 8'h10;

    // loop_factor_control fields
    localparam int          CTRL_LLA_BIT = 7;
    localparam int          CTRL_MUL_LSB = 4;
    localparam int          CTRL_CLA_BIT = 3;
    localparam int          CTRL_DIV_LSB = 0;

    // generator_status_one fields
    localparam int          STAT_MODE_LSB = 6;
    localparam int          STAT_REF_BIT  = 5;
    localparam int          STAT_LLF_BIT  = 4;
    localparam int          STAT_LOCK_BIT = 3;
    localparam int          STAT_CLF_BIT  = 2;
    localparam int          STAT_ERO_BIT  = 1;
    localparam int          STAT_IRQ_BIT  = 0;

    // event status / mask fields
    localparam int          EVT_LL_BIT   = 0;
    localparam int          EVT_CL_BIT   = 1;

    // reset values
    localparam logic [2:0]  MUL_RST      = 3'h0;
    localparam logic [2:0]  DIV_RST      = 3'h0;
    localparam logic [1:0]  MODE_RST     = 2'h0;
    localparam logic [1:0]  MASK_RST     = 2'h0;

    // loop factor: n = base + step * code
    localparam logic [4:0]  MUL_BASE     = 5'h04;

    // time for a factor write to take effect in the loop
    localparam int          CLK_PERIOD_NS  = 4;
    localparam int          SETTLE_TIME_NS = 40;
    localparam int          SETTLE_CYC     = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [7:0]  SETTLE_CNT     = 8'(SETTLE_CYC);

    typedef enum logic [1:0] {
        CGL_SELF,
        CGL_FEI,
        CGL_FBE,
        CGL_FEE
    } cgl_mode_e;

    typedef struct packed {
        logic lock_lost;
        logic locked;
        logic clock_lost;
        logic ext_ref_stable;
        logic crystal_sel;
        logic gen_off;
    } cgl_loop_s;

endpackage

//--- verilog/cgl_sync.sv
`timescale 1ns/1ps
module cgl_sync #(
    parameter int W = 2
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_ff <= '0;
            q_ff    <= '0;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;
endmodule

//--- verilog/cgl_settle.sv
`timescale 1ns/1ps
module cgl_settle
    import cgl_pkg::*;
#(
    parameter logic [2:0] RST = 3'h0
) (
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic       wr_req,
    input  wire logic [2:0] wr_data,
    output logic      [2:0] held,
    output logic      [2:0] applied,
    output logic            busy
);
    logic [2:0] held_ff;
    logic [2:0] applied_ff;
    logic [7:0] cnt_ff;

    // a new write is dropped while the previous one is still settling
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            held_ff    <= RST;
            applied_ff <= RST;
            cnt_ff     <= 8'h00;
        end else if (wr_req && cnt_ff == 8'h00) begin
            held_ff <= wr_data;
            cnt_ff  <= SETTLE_CNT;
        end else if (cnt_ff != 8'h00) begin
            cnt_ff <= cnt_ff - 8'h01;
            if (cnt_ff == 8'h01) begin
                applied_ff <= held_ff;
            end
        end
    end

    assign held    = held_ff;
    assign applied = applied_ff;
    assign busy    = (cnt_ff != 8'h00);
endmodule

//--- verilog/cgl_ctrl.sv
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
// Summary of operation
// - lock_lost action bit picks interrupt (0) or reset (1) while lock_loss_flag set
// - multiplier code k gives loop factor n = 4 + 2k, 4 to 18
// - multiplier write ignored while previous multiplier write still settling
// - clock_loss_action bit picks interrupt (0) or reset (1) on clock loss
// - divider code k gives division factor r = 2 to the power k
// - divider write ignored while previous divider write still settling
// - mode_status shows active mode, updated only through a synchroniser
// - reference_status is 0 for external clock, 1 for crystal or resonator
// - lock_loss_flag is sticky, set on unexpected lock loss until cleared
// - lock indicator follows loop lock, forced 0 in off, self-clocked, bypass
// - clock_loss_flag sets on clock loss and holds until cleared
// - ext_ref_ok reads 1 only while external reference is stable
// - irq flag set while request pending; cleared by status read then write one
// - new interrupt during clear sequence restarts it, flag stays set
// - writing zero to the irq flag bit changes nothing
// - bypassed-external mode not entered until ext_ref_ok reads 1
// - external mode with reference not stable and clock_loss_flag set falls back to self-clocked
module cgl_ctrl
    import cgl_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire cgl_pkg::cgl_loop_s loop_in,
    output logic [4:0]             loop_multiplier_n,
    output logic [7:0]             output_divider_r,
    output logic [1:0]             mode_status,
    output logic                   lock_indicator,
    output logic                   reset_req,
    output logic                   gen_irq_req,
    output logic                   irq
);
    import cgl_pkg::*;

    logic              aw_hold_ff;
    logic [ADDR_W-1:0] awaddr_ff;
    logic              w_hold_ff;
    logic [31:0]       wdata_ff;
    logic              wlane0_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              rvalid_ff;
    logic [1:0]        rresp_ff;
    logic [31:0]       rdata_ff;

    logic              lla_ff;
    logic              cla_ff;
    logic [1:0]        mode_req_ff;
    logic [1:0]        target_ff;
    logic              ll_flag_ff;
    logic              cl_flag_ff;
    logic              irq_flag_ff;
    logic              clr_armed_ff;
    logic [1:0]        evt_ff;
    logic [1:0]        mask_ff;
    logic              lock_ff;
    logic [4:0]        mul_n_ff;
    logic [7:0]        div_r_ff;

    logic              do_wr;
    logic              do_rd;
    logic              wr_ctrl;
    logic              wr_stat;
    logic              wr_evt;
    logic              wr_mask;
    logic              wr_mode;
    logic              wr_hit;
    logic [7:0]        wbyte;
    logic              rd_stat_armed;
    logic [2:0]        mul_held;
    logic [2:0]        mul_code;
    logic [2:0]        div_held;
    logic [2:0]        div_code;
    logic [1:0]        mode_sync;
    logic              engaged;
    logic              ll_evt;
    logic              cl_evt;
    logic              irq_set;
    logic [7:0]        ctrl_rd;
    logic [7:0]        stat_rd;
    logic [31:0]       nxt_rdata;
    logic [1:0]        nxt_rresp;
    logic [1:0]        nxt_target;

    // bus slave: address and data accepted in either order
    assign s_axi_awready = !aw_hold_ff && !bvalid_ff;
    assign s_axi_wready  = !w_hold_ff && !bvalid_ff;
    assign s_axi_arready = !rvalid_ff;
    assign do_wr         = aw_hold_ff && w_hold_ff && !bvalid_ff;
    assign do_rd         = s_axi_arvalid && !rvalid_ff;
    assign wbyte         = wdata_ff[7:0];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_hold_ff <= 1'b0;
            awaddr_ff  <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_ff <= 1'b1;
            awaddr_ff  <= s_axi_awaddr;
        end else if (do_wr) begin
            aw_hold_ff <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            w_hold_ff <= 1'b0;
            wdata_ff  <= 32'h0000_0000;
            wlane0_ff <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_hold_ff <= 1'b1;
            wdata_ff  <= s_axi_wdata;
            wlane0_ff <= s_axi_wstrb[0];
        end else if (do_wr) begin
            w_hold_ff <= 1'b0;
        end
    end

    // address decode; registers live in byte lane 0 only
    always_comb begin
        wr_ctrl = 1'b0;
        wr_stat = 1'b0;
        wr_evt  = 1'b0;
        wr_mask = 1'b0;
        wr_mode = 1'b0;
        wr_hit  = 1'b1;
        if (awaddr_ff == OFF_CTRL) begin
            wr_ctrl = do_wr && wlane0_ff;
        end else if (awaddr_ff == OFF_STAT) begin
            wr_stat = do_wr && wlane0_ff;
        end else if (awaddr_ff == OFF_EVT) begin
            wr_evt = do_wr && wlane0_ff;
        end else if (awaddr_ff == OFF_MASK) begin
            wr_mask = do_wr && wlane0_ff;
        end else if (awaddr_ff == OFF_MODE) begin
            wr_mode = do_wr && wlane0_ff;
        end else begin
            wr_hit = 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp  = bresp_ff;

    // control bits written directly
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lla_ff <= 1'b0;
            cla_ff <= 1'b0;
        end else if (wr_ctrl) begin
            lla_ff <= wbyte[CTRL_LLA_BIT];
            cla_ff <= wbyte[CTRL_CLA_BIT];
        end
    end

    cgl_settle #(
        .RST     (MUL_RST)
    ) u_mul (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_req   (wr_ctrl),
        .wr_data  (wbyte[CTRL_MUL_LSB +: 3]),
        .held     (mul_held),
        .applied  (mul_code),
        .busy     ()
    );

    cgl_settle #(
        .RST     (DIV_RST)
    ) u_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_req   (wr_ctrl),
        .wr_data  (wbyte[CTRL_DIV_LSB +: 3]),
        .held     (div_held),
        .applied  (div_code),
        .busy     ()
    );

    // factor decode registered for the loop
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mul_n_ff <= MUL_BASE;
            div_r_ff <= 8'h01;
        end else begin
            mul_n_ff <= MUL_BASE + {1'b0, mul_code, 1'b0};
            div_r_ff <= 8'h01 << div_code;
        end
    end

    assign loop_multiplier_n = mul_n_ff;
    assign output_divider_r  = div_r_ff;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_req_ff <= MODE_RST;
        end else if (wr_mode) begin
            mode_req_ff <= wbyte[1:0];
        end
    end

    // mode selection; bypass must wait for a good reference
    always_comb begin
        nxt_target = mode_req_ff;
        if (mode_req_ff[1] && !loop_in.ext_ref_stable && cl_flag_ff) begin
            nxt_target = CGL_SELF;
        end else if (mode_req_ff == CGL_FBE && !loop_in.ext_ref_stable) begin
            nxt_target = target_ff;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            target_ff <= MODE_RST;
        end else begin
            target_ff <= nxt_target;
        end
    end

    cgl_sync #(
        .W        (2)
    ) u_mode_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        (target_ff),
        .q        (mode_sync)
    );

    assign mode_status = mode_sync;
    assign engaged     = !loop_in.gen_off && (mode_sync == CGL_FEI || mode_sync == CGL_FEE);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_ff <= 1'b0;
        end else begin
            lock_ff <= loop_in.locked && engaged;
        end
    end

    assign lock_indicator = lock_ff;

    // lock loss only counts when the loop was meant to be locked
    assign ll_evt  = loop_in.lock_lost && engaged;
    assign cl_evt  = loop_in.clock_lost;
    assign irq_set = (ll_evt && !lla_ff) || (cl_evt && !cla_ff);

    // sticky lock loss, set beats clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ll_flag_ff <= 1'b0;
        end else if (ll_evt) begin
            ll_flag_ff <= 1'b1;
        end else if (wr_stat && wbyte[STAT_LLF_BIT]) begin
            ll_flag_ff <= 1'b0;
        end
    end

    // sticky clock loss, set beats clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cl_flag_ff <= 1'b0;
        end else if (cl_evt) begin
            cl_flag_ff <= 1'b1;
        end else if (wr_stat && wbyte[STAT_CLF_BIT]) begin
            cl_flag_ff <= 1'b0;
        end
    end

    // read with flag set arms the clear
    assign rd_stat_armed = do_rd && s_axi_araddr == OFF_STAT && irq_flag_ff;

    // a new interrupt request disarms and keeps the flag
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clr_armed_ff <= 1'b0;
        end else if (irq_set) begin
            clr_armed_ff <= 1'b0;
        end else if (rd_stat_armed) begin
            clr_armed_ff <= 1'b1;
        end else if (wr_stat && wbyte[STAT_IRQ_BIT]) begin
            clr_armed_ff <= 1'b0;
        end
    end

    // only a one with the sequence armed clears
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag_ff <= 1'b0;
        end else if (irq_set) begin
            irq_flag_ff <= 1'b1;
        end else if (wr_stat && wbyte[STAT_IRQ_BIT] && clr_armed_ff) begin
            irq_flag_ff <= 1'b0;
        end
    end

    assign gen_irq_req = irq_flag_ff;
    // lock-loss action only while its flag is set
    // clock-loss action picks the reset request
    assign reset_req   = (ll_flag_ff && lla_ff) || (cl_flag_ff && cla_ff);

    // event status for the system interrupt line, write one to clear
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_ff <= 2'h0;
        end else begin
            evt_ff[EVT_LL_BIT] <= ll_evt || (evt_ff[EVT_LL_BIT] && !(wr_evt && wbyte[EVT_LL_BIT]));
            evt_ff[EVT_CL_BIT] <= cl_evt || (evt_ff[EVT_CL_BIT] && !(wr_evt && wbyte[EVT_CL_BIT]));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_ff <= MASK_RST;
        end else if (wr_mask) begin
            mask_ff <= wbyte[1:0];
        end
    end

    assign irq = |(evt_ff & mask_ff);

    // readback shows the last accepted factor write
    assign ctrl_rd = {lla_ff, mul_held, cla_ff, div_held};
    // reference select straight from the loop
    // external reference health straight from the loop
    assign stat_rd = {mode_sync, loop_in.crystal_sel, ll_flag_ff, lock_ff,
                      cl_flag_ff, loop_in.ext_ref_stable, irq_flag_ff};

    always_comb begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = RESP_OKAY;
        if (s_axi_araddr == OFF_CTRL) begin
            nxt_rdata[7:0] = ctrl_rd;
        end else if (s_axi_araddr == OFF_STAT) begin
            nxt_rdata[7:0] = stat_rd;
        end else if (s_axi_araddr == OFF_EVT) begin
            nxt_rdata[1:0] = evt_ff;
        end else if (s_axi_araddr == OFF_MASK) begin
            nxt_rdata[1:0] = mask_ff;
        end else if (s_axi_araddr == OFF_MODE) begin
            nxt_rdata[1:0] = mode_req_ff;
        end else begin
            nxt_rresp = RESP_SLVERR;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_ff <= 1'b0;
            rresp_ff  <= RESP_OKAY;
            rdata_ff  <= 32'h0000_0000;
        end else if (do_rd) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= nxt_rresp;
            rdata_ff  <= nxt_rdata;
        end else if (s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rresp  = rresp_ff;
    assign s_axi_rdata  = rdata_ff;
endmodule

//--- dv/cgl_ctrl_monitor.sv
`timescale 1ns/1ps
module cgl_ctrl_monitor
    import cgl_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               rst_n,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire cgl_pkg::cgl_loop_s loop_in,
    input wire logic [4:0]         loop_multiplier_n,
    input wire logic [7:0]         output_divider_r,
    input wire logic [1:0]         mode_status,
    input wire logic               lock_indicator,
    input wire logic               reset_req,
    input wire logic               gen_irq_req,
    input wire logic               irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic ev;
    // any loss event pulse; flags follow one edge later
    assign ev = loop_in.lock_lost | loop_in.clock_lost;

    chk_mul_legal: assert property (!loop_multiplier_n[0] && loop_multiplier_n inside {[4:18]})
        else $error("loop factor outside the even range 4 to 18");
    chk_mul_settle: assert property ($changed(loop_multiplier_n) |=> $stable(loop_multiplier_n) [*8])
        else $error("loop factor changed while settling");
    chk_div_legal: assert property ($onehot(output_divider_r))
        else $error("divide factor not a power of two");
    chk_div_settle: assert property ($changed(output_divider_r) |=> $stable(output_divider_r) [*8])
        else $error("divide factor changed while settling");
    chk_lock_mode: assert property (lock_indicator |-> $past(mode_status[0] && loop_in.locked && !loop_in.gen_off))
        else $error("lock shown outside an engaged mode");
    chk_bypass_ref: assert property ($changed(mode_status) && mode_status == 2'b10 |->
        $past(loop_in.ext_ref_stable, 2) || $past(loop_in.ext_ref_stable, 3) || $past(loop_in.ext_ref_stable, 4))
        else $error("bypass entered without stable reference");
    chk_irq_cause: assert property ($rose(gen_irq_req) |-> $past(ev))
        else $error("irq flag set without a loss event");
    chk_irq_clear: assert property ($fell(gen_irq_req) |-> $rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY)
        else $error("irq flag cleared without a register write");
    chk_rst_cause: assert property ($rose(reset_req) |-> $past(ev) || $rose(s_axi_bvalid))
        else $error("reset request without event or write");
    chk_line_cause: assert property ($rose(irq) |-> $past(ev) || $rose(s_axi_bvalid))
        else $error("interrupt line rose without cause");

    cov_irq_clear: cover property ($fell(gen_irq_req));
    cov_rst_req: cover property ($rose(reset_req));
    cov_bypass: cover property (mode_status == 2'b10);
    cov_line: cover property ($rose(irq));
endmodule

bind cgl_ctrl cgl_ctrl_monitor u_mon (
    .core_clk, .rst_n, .s_axi_bresp, .s_axi_bvalid, .loop_in, .loop_multiplier_n, .output_divider_r,
    .mode_status, .lock_indicator, .reset_req, .gen_irq_req, .irq
);

//--- dv/cgl_ctrl_tb_top.sv
`timescale 1ns/1ps
module cgl_ctrl_tb_top;
    import cgl_pkg::*;
    logic              core_clk = 1'b0, rst_n = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, rdv;
    logic [3:0]        s_axi_wstrb = 4'hf;
    logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]        s_axi_bresp, s_axi_rresp, mode_status, rs;
    cgl_loop_s         loop_in = '0;
    logic [4:0]        loop_multiplier_n;
    logic [7:0]        output_divider_r;
    logic              lock_indicator, reset_req, gen_irq_req, irq;
    logic [2:0]        dv;
    int                error_cnt = 0, n_tests = 0, cyc = 0, k;

    cgl_ctrl dut (
        .core_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .loop_in, .loop_multiplier_n, .output_divider_r, .mode_status, .lock_indicator, .reset_req,
        .gen_irq_req, .irq
    );

    always #2 core_clk = ~core_clk;

    // whole run is under 2000 cycles; the ceiling only catches a hung handshake
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 8000) begin
            error_cnt++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, seen, exp);
        end
    endtask

    // both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er), "write response");
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        rdv = s_axi_rdata;
        rs = s_axi_rresp;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string m);
        rd(a);
        check(rdv, e, m);
    endtask

    // one-cycle loss event: clock loss or lock loss
    task automatic pulse(input logic clk_loss);
        @(posedge core_clk);
        loop_in.clock_lost <= clk_loss;
        loop_in.lock_lost <= !clk_loss;
        @(posedge core_clk);
        loop_in.clock_lost <= 1'b0;
        loop_in.lock_lost <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask

    function automatic logic [31:0] st(input logic [1:0] m, input logic lk, llf, clf, f);
        return {24'h0, m, loop_in.crystal_sel, llf, lk, clf, loop_in.ext_ref_stable, f};
    endfunction

    initial begin
        k = $urandom(32'h20d8fea2);
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        check(32'(loop_multiplier_n), 32'h4, "reset factor");
        check(32'(output_divider_r), 32'h1, "reset divider");
        rdc(OFF_CTRL, 32'h0, "ctrl reset");
        rdc(OFF_STAT, 32'h0, "status reset");
        rdc(OFF_MASK, 32'h0, "mask reset");
        // lane 0 strobe low: answered but nothing may change
        s_axi_wstrb <= 4'h0;
        wr(OFF_MASK, 32'h3, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rdc(OFF_MASK, 32'h0, "lane 0 off");
        rd(8'h14);
        check({rdv[29:0], rs}, 32'h2, "unmapped read");
        wr(8'h14, 32'hff, RESP_SLVERR);
        // no reference frequency modelled, so every code is within limits
        for (int i = 0; i < 8; i++) begin
            dv = 3'(7 - i);
            wr(OFF_CTRL, {24'h0, 1'b0, 3'(i), 1'b0, dv}, RESP_OKAY);
            wr(OFF_CTRL, {24'h0, 1'b0, 3'($urandom), 1'b0, 3'($urandom)}, RESP_OKAY);
            repeat (14) @(posedge core_clk);
            check(32'(loop_multiplier_n), 32'h4 + 32'h2 * 32'(i), "factor");
            check(32'(output_divider_r), 32'h1 << dv, "divider");
            rdc(OFF_CTRL, {24'h0, 1'b0, 3'(i), 1'b0, dv}, "ctrl readback");
        end
        loop_in.locked <= 1'b1;
        loop_in.crystal_sel <= 1'($urandom);
        loop_in.ext_ref_stable <= 1'($urandom);
        wr(OFF_MODE, 32'h1, RESP_OKAY);
        repeat (6) @(posedge core_clk);
        check(32'(lock_indicator), 32'h1, "lock");
        rdc(OFF_STAT, st(2'b01, 1'b1, 1'b0, 1'b0, 1'b0), "status");
        loop_in.gen_off <= 1'b1;
        repeat (3) @(posedge core_clk);
        check(32'(lock_indicator), 32'h0, "lock off");
        loop_in.gen_off <= 1'b0;
        wr(OFF_MASK, 32'h3, RESP_OKAY);
        pulse(1'b1);
        check(32'({reset_req, gen_irq_req, irq}), 32'h3, "clock loss irq");
        rdc(OFF_STAT, st(2'b01, 1'b1, 1'b0, 1'b1, 1'b1), "clock loss flag");
        wr(OFF_STAT, 32'h0, RESP_OKAY);
        check(32'(gen_irq_req), 32'h1, "zero write");
        rd(OFF_STAT);
        pulse(1'b0);
        wr(OFF_STAT, 32'h1, RESP_OKAY);
        check(32'(gen_irq_req), 32'h1, "restarted clear");
        rdc(OFF_STAT, st(2'b01, 1'b1, 1'b1, 1'b1, 1'b1), "both flags");
        wr(OFF_STAT, 32'h15, RESP_OKAY);
        check(32'({reset_req, gen_irq_req}), 32'h0, "irq cleared");
        rdc(OFF_EVT, 32'h3, "event status");
        wr(OFF_MASK, 32'h0, RESP_OKAY);
        check(32'(irq), 32'h0, "masked");
        wr(OFF_MASK, 32'h3, RESP_OKAY);
        check(32'(irq), 32'h1, "unmasked");
        wr(OFF_EVT, 32'h3, RESP_OKAY);
        check(32'(irq), 32'h0, "event cleared");
        wr(OFF_CTRL, 32'h88, RESP_OKAY);
        pulse(1'b1);
        check(32'({reset_req, gen_irq_req}), 32'h2, "clock loss reset");
        pulse(1'b0);
        wr(OFF_STAT, 32'h04, RESP_OKAY);
        check(32'(reset_req), 32'h1, "lock loss reset");
        wr(OFF_STAT, 32'h10, RESP_OKAY);
        check(32'(reset_req), 32'h0, "reset dropped");
        loop_in.ext_ref_stable <= 1'b0;
        wr(OFF_MODE, 32'h2, RESP_OKAY);
        repeat (6) @(posedge core_clk);
        check(32'(mode_status), 32'h1, "bypass held off");
        loop_in.ext_ref_stable <= 1'b1;
        wr(OFF_MODE, 32'h2, RESP_OKAY);
        repeat (6) @(posedge core_clk);
        check(32'(mode_status), 32'h2, "bypass");
        check(32'(lock_indicator), 32'h0, "bypass lock");
        loop_in.ext_ref_stable <= 1'b0;
        wr(OFF_MODE, 32'h3, RESP_OKAY);
        pulse(1'b1);
        repeat (6) @(posedge core_clk);
        check(32'(mode_status), 32'h0, "fallback");
        finish_test();
    end
endmodule
